//--- flash_tbl_pkg.sv
// Shared constants, types and carriers for the table access sequencer
package flash_tbl_pkg;

  localparam int          CLK_NS     = 100;
  localparam int          LONG_NS    = 2_000_000;
  localparam int          LONG_CYC   = LONG_NS / CLK_NS;
  localparam int          TIMER_W    = 16;
  localparam int          PTR_W      = 22;
  localparam int          HOLD_N     = 64;

  // Register indices
  localparam logic [2:0]  IDX_PTRL   = 3'h0;
  localparam logic [2:0]  IDX_PTRH   = 3'h1;
  localparam logic [2:0]  IDX_PTRU   = 3'h2;
  localparam logic [2:0]  IDX_LATCH  = 3'h3;
  localparam logic [2:0]  IDX_CTL    = 3'h4;
  localparam logic [2:0]  IDX_UNLOCK = 3'h5;
  localparam logic [2:0]  IDX_STAT   = 3'h6;

  // Control and status register fields
  localparam int          B_PROG     = 7;
  localparam int          B_CFG      = 6;
  localparam int          B_ERASE    = 4;
  localparam int          B_ERR      = 3;
  localparam int          B_WRITE_ENABLE_BIT     = 2;
  localparam int          B_START    = 1;
  localparam int          B_DONE     = 0;

  localparam logic [7:0]  KEY1       = 8'h55;
  localparam logic [7:0]  KEY2       = 8'haa;
  localparam logic [7:0]  BLANK      = 8'hff;

  typedef enum logic [1:0] {
    PM_KEEP    = 2'h0,
    PM_POSTINC = 2'h1,
    PM_POSTDEC = 2'h2,
    PM_PREINC  = 2'h3
  } ptr_mode_e;

  typedef enum logic [1:0] {
    UL_NONE  = 2'h0,
    UL_FIRST = 2'h1,
    UL_OPEN  = 2'h2
  } unlock_e;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_PRD   = 3'h1,
    S_PWR   = 3'h3,
    S_PWAIT = 3'h2,
    S_ERASE = 3'h6
  } seq_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic      valid;
    logic      write;
    ptr_mode_e mode;
  } tbl_req_s;

  typedef struct packed {
    logic        rdEn;
    logic [20:0] rdAddr;
    logic        write_enable_bit;
    logic [21:0] wrAddr;
    logic [7:0]  wrData;
    logic        eraseEn;
    logic [15:0] rowAddr;
  } arr_req_s;

  typedef struct packed {
    seq_e                      st;
    logic [PTR_W-1:0]          ptr;
    logic [7:0]                latch;
    logic                      progSel;
    logic                      cfgSel;
    logic                      rowErase;
    logic                      write_error_flag;
    logic                      write_enable_bit;
    logic                      wrStart;
    logic                      done;
    unlock_e                   unlock;
    logic [TIMER_W-1:0]        timer;
    logic [5:0]                idx;
    logic [HOLD_N-1:0][7:0]    hold;
    logic                      rdPend;
    logic                      rdLsb;
    logic                      fresh;
    logic                      stall;
    logic [7:0]                rData;
    arr_req_s                  arr;
  } state_s;

endpackage : flash_tbl_pkg

//--- flash_table_seq.sv
// Program-flash table access and self-programming sequencer
`timescale 1ns/1ps

module flash_table_seq #(
  parameter int LONG_CYC = flash_tbl_pkg::LONG_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   porN,
  input  wire logic                   clkEn,
  input  wire flash_tbl_pkg::reg_req_s regReq,
  input  wire flash_tbl_pkg::tbl_req_s tblReq,
  input  wire logic [15:0]            arrRdData,
  output logic [7:0]                  regRData,
  output logic                        stall,
  output logic                        doneFlag,
  output flash_tbl_pkg::arr_req_s     arrReq
);

  localparam int         TW = flash_tbl_pkg::TIMER_W;

  flash_tbl_pkg::state_s s_r;
  flash_tbl_pkg::state_s s_nxt;
  logic [1:0]            rstSync_r;
  logic                  busyMark_r;
  logic [21:0]           effPtr;
  logic [7:0]            ctlRead;
  logic                  startOk;

  assign regRData = s_r.rData;
  assign stall    = s_r.stall;
  assign doneFlag = s_r.done;
  assign arrReq   = s_r.arr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  // Survives the device reset so an interrupted long write can be flagged
  always_ff @(posedge clk or negedge porN) begin
    if (!porN) begin
      busyMark_r <= 1'b0;
    end else if (clkEn && rstSync_r[1]) begin
      busyMark_r <= s_r.stall;
    end
  end

  always_comb begin
    ctlRead = {s_r.progSel, s_r.cfgSel, 1'b0, s_r.rowErase,
               s_r.write_error_flag, s_r.write_enable_bit, s_r.wrStart, 1'b0};
    effPtr = s_r.ptr;
    if (tblReq.mode == flash_tbl_pkg::PM_PREINC) begin
      effPtr = {s_r.ptr[21], s_r.ptr[20:0] + 21'h1};
    end
    startOk = s_r.unlock == flash_tbl_pkg::UL_OPEN && s_r.write_enable_bit
              && s_r.progSel && !s_r.cfgSel;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.arr.rdEn    = 1'b0;
    s_nxt.arr.write_enable_bit    = 1'b0;
    s_nxt.arr.eraseEn = 1'b0;
    if (regReq.rd) begin
      unique case (regReq.addr)
        flash_tbl_pkg::IDX_PTRL:  s_nxt.rData = s_r.ptr[7:0];
        flash_tbl_pkg::IDX_PTRH:  s_nxt.rData = s_r.ptr[15:8];
        flash_tbl_pkg::IDX_PTRU:  s_nxt.rData = {2'h0, s_r.ptr[21:16]};
        flash_tbl_pkg::IDX_LATCH: s_nxt.rData = s_r.latch;
        flash_tbl_pkg::IDX_CTL:   s_nxt.rData = ctlRead;
        flash_tbl_pkg::IDX_STAT:  s_nxt.rData = {7'h0, s_r.done};
        default:                  s_nxt.rData = 8'h00;
      endcase
    end
    if ((regReq.rd || regReq.wr) && regReq.addr == flash_tbl_pkg::IDX_UNLOCK) begin
      if (regReq.wr && regReq.wdata == flash_tbl_pkg::KEY1) begin
        s_nxt.unlock = flash_tbl_pkg::UL_FIRST;
      end else if (regReq.wr && regReq.wdata == flash_tbl_pkg::KEY2
                   && s_r.unlock == flash_tbl_pkg::UL_FIRST) begin
        s_nxt.unlock = flash_tbl_pkg::UL_OPEN;
      end else begin
        s_nxt.unlock = flash_tbl_pkg::UL_NONE;
      end
    end
    if (regReq.wr) begin
      unique case (regReq.addr)
        flash_tbl_pkg::IDX_PTRL:  s_nxt.ptr[7:0]   = regReq.wdata;
        flash_tbl_pkg::IDX_PTRH:  s_nxt.ptr[15:8]  = regReq.wdata;
        flash_tbl_pkg::IDX_PTRU:  s_nxt.ptr[21:16] = regReq.wdata[5:0];
        flash_tbl_pkg::IDX_LATCH: s_nxt.latch      = regReq.wdata;
        flash_tbl_pkg::IDX_STAT: begin
          if (!regReq.wdata[flash_tbl_pkg::B_DONE]) begin
            s_nxt.done = 1'b0;
          end
        end
        flash_tbl_pkg::IDX_CTL: begin
          s_nxt.progSel  = regReq.wdata[flash_tbl_pkg::B_PROG];
          s_nxt.cfgSel   = regReq.wdata[flash_tbl_pkg::B_CFG];
          s_nxt.rowErase = regReq.wdata[flash_tbl_pkg::B_ERASE] ||
                           (s_r.rowErase && s_r.st != flash_tbl_pkg::S_IDLE);
          s_nxt.write_error_flag    = regReq.wdata[flash_tbl_pkg::B_ERR];
          s_nxt.write_enable_bit     = regReq.wdata[flash_tbl_pkg::B_WRITE_ENABLE_BIT];
          // Start bit only sets; a zero written is ignored
          if (regReq.wdata[flash_tbl_pkg::B_START] && s_r.st == flash_tbl_pkg::S_IDLE) begin
            s_nxt.unlock = flash_tbl_pkg::UL_NONE;
            if (startOk) begin
              s_nxt.wrStart = 1'b1;
              s_nxt.write_error_flag   = 1'b1;
              s_nxt.stall   = 1'b1;
              s_nxt.timer   = TW'(LONG_CYC - 1);
              s_nxt.idx     = 6'h0;
              if (regReq.wdata[flash_tbl_pkg::B_ERASE]) begin
                s_nxt.st          = flash_tbl_pkg::S_ERASE;
                s_nxt.arr.eraseEn = 1'b1;
                s_nxt.arr.rowAddr = s_r.ptr[21:6];
              end else begin
                s_nxt.st = flash_tbl_pkg::S_PRD;
              end
            end else begin
              s_nxt.write_error_flag = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    // Reset mark wins over a control write in the same cycle
    if (s_r.fresh) begin
      s_nxt.fresh = 1'b0;
      if (busyMark_r) begin
        s_nxt.write_error_flag = 1'b1;
      end
    end
    if (s_r.rdPend) begin
      s_nxt.rdPend = 1'b0;
      s_nxt.latch  = s_r.rdLsb ? arrRdData[15:8] : arrRdData[7:0];
    end
    if (tblReq.valid && !s_r.rdPend && s_r.st == flash_tbl_pkg::S_IDLE) begin
      if (tblReq.write) begin
        s_nxt.hold[effPtr[5:0]] = s_r.latch;
      end else begin
        s_nxt.arr.rdEn   = 1'b1;
        s_nxt.arr.rdAddr = effPtr[21:1];
        s_nxt.rdLsb      = effPtr[0];
        s_nxt.rdPend     = 1'b1;
      end
      unique case (tblReq.mode)
        flash_tbl_pkg::PM_POSTINC: s_nxt.ptr = {effPtr[21], effPtr[20:0] + 21'h1};
        flash_tbl_pkg::PM_POSTDEC: s_nxt.ptr = {effPtr[21], effPtr[20:0] - 21'h1};
        default:                   s_nxt.ptr = effPtr;
      endcase
    end
    if (s_r.st != flash_tbl_pkg::S_IDLE && s_r.timer != '0) begin
      s_nxt.timer = s_r.timer - TW'(1);
    end
    unique case (s_r.st)
      flash_tbl_pkg::S_IDLE: ;
      flash_tbl_pkg::S_PRD: begin
        if (s_r.hold[s_r.idx] == flash_tbl_pkg::BLANK) begin
          s_nxt.idx = s_r.idx + 6'h1;
          if (s_r.idx == 6'h3f) begin
            s_nxt.st = flash_tbl_pkg::S_PWAIT;
          end
        end else begin
          s_nxt.arr.rdEn   = 1'b1;
          s_nxt.arr.rdAddr = {s_r.ptr[21:6], s_r.idx[5:1]};
          s_nxt.st         = flash_tbl_pkg::S_PWR;
        end
      end
      flash_tbl_pkg::S_PWR: begin
        s_nxt.arr.write_enable_bit   = 1'b1;
        s_nxt.arr.wrAddr = {s_r.ptr[21:6], s_r.idx};
        s_nxt.arr.wrData = s_r.hold[s_r.idx] &
                           (s_r.idx[0] ? arrRdData[15:8] : arrRdData[7:0]);
        s_nxt.idx        = s_r.idx + 6'h1;
        s_nxt.st         = (s_r.idx == 6'h3f) ? flash_tbl_pkg::S_PWAIT : flash_tbl_pkg::S_PRD;
      end
      flash_tbl_pkg::S_PWAIT, flash_tbl_pkg::S_ERASE: begin
        if (s_r.timer == '0) begin
          s_nxt.st      = flash_tbl_pkg::S_IDLE;
          s_nxt.stall   = 1'b0;
          s_nxt.wrStart = 1'b0;
          s_nxt.write_error_flag   = 1'b0;
          s_nxt.done    = 1'b1;
          if (s_r.st == flash_tbl_pkg::S_ERASE) begin
            s_nxt.rowErase = 1'b0;
          end else begin
            s_nxt.hold = '1;
          end
        end
      end
      default: s_nxt.st = flash_tbl_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_r[1]) begin
    if (!rstSync_r[1]) begin
      s_r       <= '0;
      s_r.hold  <= '1;
      s_r.fresh <= 1'b1;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_r[1]);

  property p_ptrStep;
    clkEn && tblReq.valid && !regReq.wr && s_r.st == flash_tbl_pkg::S_IDLE && !s_r.rdPend
      && tblReq.mode == flash_tbl_pkg::PM_POSTINC
      |=> s_r.ptr == {$past(s_r.ptr[21]), $past(s_r.ptr[20:0]) + 21'h1};
  endproperty
  a_ptrStep: assert property (p_ptrStep) else $error("pointer step wrong");

  property p_holdLoad;
    clkEn && tblReq.valid && tblReq.write && tblReq.mode == flash_tbl_pkg::PM_KEEP
      && s_r.st == flash_tbl_pkg::S_IDLE && !s_r.rdPend
      |=> s_r.hold[$past(s_r.ptr[5:0])] == $past(s_r.latch) && !arrReq.write_enable_bit;
  endproperty
  a_holdLoad: assert property (p_holdLoad) else $error("holding load wrong");

  sequence sq_readIssue;
    clkEn && tblReq.valid && !tblReq.write && s_r.st == flash_tbl_pkg::S_IDLE && !s_r.rdPend;
  endsequence
  property p_readByte;
    sq_readIssue ##1 clkEn && !(regReq.wr && regReq.addr == flash_tbl_pkg::IDX_LATCH)
      |=> s_r.latch == ($past(s_r.rdLsb) ? $past(arrRdData[15:8]) : $past(arrRdData[7:0]));
  endproperty
  a_readByte: assert property (p_readByte) else $error("read byte lane wrong");

  property p_startKeyed;
    $rose(stall) |-> $past(s_r.unlock) == flash_tbl_pkg::UL_OPEN && $past(s_r.write_enable_bit);
  endproperty
  a_startKeyed: assert property (p_startKeyed) else $error("start without unlock");

  property p_endOnTimer;
    $fell(stall) |-> $past(s_r.timer) == '0 && !s_r.wrStart && s_r.done;
  endproperty
  a_endOnTimer: assert property (p_endOnTimer) else $error("long write ended early");

  property p_holdBlank;
    $fell(stall) && $past(s_r.st) == flash_tbl_pkg::S_PWAIT |-> s_r.hold == '1;
  endproperty
  a_holdBlank: assert property (p_holdBlank) else $error("holding not blank");

  property p_eraseRow;
    arrReq.eraseEn |-> arrReq.rowAddr == s_r.ptr[21:6] && s_r.st == flash_tbl_pkg::S_ERASE;
  endproperty
  a_eraseRow: assert property (p_eraseRow) else $error("erase row wrong");

  property p_unlockZero;
    clkEn && regReq.rd && regReq.addr == flash_tbl_pkg::IDX_UNLOCK |=> regRData == 8'h00;
  endproperty
  a_unlockZero: assert property (p_unlockZero) else $error("unlock read not zero");

  property p_noSetBit;
    arrReq.write_enable_bit |-> (arrReq.wrData & ~s_r.hold[arrReq.wrAddr[5:0]]) == 8'h00;
  endproperty
  a_noSetBit: assert property (p_noSetBit) else $error("program sets a bit");

  property p_refusedStart;
    clkEn && regReq.wr && regReq.addr == flash_tbl_pkg::IDX_CTL
      && regReq.wdata[flash_tbl_pkg::B_START] && s_r.st == flash_tbl_pkg::S_IDLE
      && s_r.unlock != flash_tbl_pkg::UL_OPEN |=> s_r.write_error_flag && !stall;
  endproperty
  a_refusedStart: assert property (p_refusedStart) else $error("refused start not flagged");

  property p_doneHeld;
    doneFlag && !(clkEn && regReq.wr && regReq.addr == flash_tbl_pkg::IDX_STAT
                  && !regReq.wdata[flash_tbl_pkg::B_DONE]) |=> doneFlag;
  endproperty
  a_doneHeld: assert property (p_doneHeld) else $error("done flag dropped by itself");

endmodule : flash_table_seq

//--- flash_array_model.sv
// Behavioural program-flash array facing the sequencer
`timescale 1ns/1ps

module flash_array_model (
  input  wire logic                    clk,
  input  wire flash_tbl_pkg::arr_req_s arrReq,
  output logic [15:0]                  arrRdData
);
  logic [7:0] mem [logic [21:0]];
  int         upd = 0;

  function automatic logic [7:0] peek(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[21:14]);
  endfunction : peek

  // Outside a read the word is inverted so stale data never matches
  always @(arrReq or upd) begin
    arrRdData = {peek({arrReq.rdAddr, 1'b1}), peek({arrReq.rdAddr, 1'b0})};
    if (arrReq.rdEn !== 1'b1) arrRdData = ~arrRdData;
  end

  always @(posedge clk) begin
    if (arrReq.write_enable_bit === 1'b1) begin
      mem[arrReq.wrAddr] = peek(arrReq.wrAddr) & arrReq.wrData;
      upd++;
    end
    if (arrReq.eraseEn === 1'b1) begin
      for (int i = 0; i < 64; i++) mem[{arrReq.rowAddr, i[5:0]}] = 8'hff;
      upd++;
    end
  end
endmodule : flash_array_model

//--- flash_self_program_table_access_test.sv
// Testbench for the table access and self-programming sequencer
`timescale 1ns/1ps

module flash_self_program_table_access_test;
  localparam int LC = 200;
  typedef struct packed {
    logic [21:0]              p;
    flash_tbl_pkg::ptr_mode_e m;
    logic [21:0]              a;
    logic [21:0]              q;
  } row_s;
  row_s rows [6] = '{
    '{22'h000011, flash_tbl_pkg::PM_KEEP,    22'h000011, 22'h000011},
    '{22'h000011, flash_tbl_pkg::PM_POSTINC, 22'h000011, 22'h000012},
    '{22'h000010, flash_tbl_pkg::PM_POSTDEC, 22'h000010, 22'h00000f},
    '{22'h000010, flash_tbl_pkg::PM_PREINC,  22'h000011, 22'h000011},
    '{22'h1fffff, flash_tbl_pkg::PM_POSTINC, 22'h1fffff, 22'h000000},
    '{22'h200000, flash_tbl_pkg::PM_POSTDEC, 22'h200000, 22'h3fffff}};
  logic [7:0]              badC [4] = '{8'h80, 8'h84, 8'h84, 8'hc4};
  logic [7:0]              badK [4] = '{8'haa, 8'h55, 8'haa, 8'haa};
  logic                    clk;
  logic                    rstn;
  logic                    porN;
  logic                    clkEn;
  flash_tbl_pkg::reg_req_s regReq;
  flash_tbl_pkg::tbl_req_s tblReq;
  logic [15:0]             arrRdData;
  logic [7:0]              regRData;
  logic                    stall;
  logic                    doneFlag;
  flash_tbl_pkg::arr_req_s arrReq;
  logic [7:0]              rv;
  logic [7:0]              o0;
  logic [21:0]             p;
  logic [15:0]             erRow;
  int                      mismatches = 0;
  int                      checksDone = 0;
  int                      wrCnt = 0;
  int                      erCnt = 0;

  flash_table_seq #(.LONG_CYC(LC)) i_flash_table_seq (
    .clk(clk), .rstn(rstn), .porN(porN), .clkEn(clkEn), .regReq(regReq), .tblReq(tblReq),
    .arrRdData(arrRdData), .regRData(regRData), .stall(stall), .doneFlag(doneFlag),
    .arrReq(arrReq));
  flash_array_model i_flash_array_model (.clk(clk), .arrReq(arrReq), .arrRdData(arrRdData));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (arrReq.write_enable_bit === 1'b1) wrCnt++;
    if (arrReq.eraseEn === 1'b1) begin
      erCnt++;
      erRow = arrReq.rowAddr;
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic go();
    @(posedge clk);
    #10;
  endtask : go

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic regWr(input logic [2:0] a, input logic [7:0] d);
    go();
    regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    go();
    regReq.wr = 1'b0;
  endtask : regWr

  task automatic regRd(input logic [2:0] a, output logic [7:0] d);
    go();
    regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    go();
    regReq.rd = 1'b0;
    d = regRData;
  endtask : regRd

  task automatic tbl(input logic w, input flash_tbl_pkg::ptr_mode_e m);
    go();
    tblReq = '{valid: 1'b1, write: w, mode: m};
    go();
    tblReq.valid = 1'b0;
  endtask : tbl

  // Top two bits of the upper byte are junk on purpose
  task automatic setPtr(input logic [21:0] v);
    regWr(flash_tbl_pkg::IDX_PTRL, v[7:0]);
    regWr(flash_tbl_pkg::IDX_PTRH, v[15:8]);
    regWr(flash_tbl_pkg::IDX_PTRU, {2'h3, v[21:16]});
  endtask : setPtr

  task automatic unlockStart(input logic [7:0] c, input logic [7:0] k2, input logic midRd);
    regWr(flash_tbl_pkg::IDX_CTL, c);
    regWr(flash_tbl_pkg::IDX_UNLOCK, 8'h55);
    if (midRd) regRd(flash_tbl_pkg::IDX_UNLOCK, rv);
    regWr(flash_tbl_pkg::IDX_UNLOCK, k2);
    regWr(flash_tbl_pkg::IDX_CTL, c | 8'h02);
  endtask : unlockStart

  task automatic start(input logic [7:0] c, input logic [7:0] k2, input logic midRd,
                       input logic ok);
    int n;
    n = 0;
    unlockStart(c, k2, midRd);
    chk(stall, ok);
    while (stall === 1'b1 && n < LC + 9) begin
      go();
      n++;
    end
    if (n >= LC + 9) begin
      mismatches++;
      give_verdict();
    end
    if (ok) chk(n, LC);
    chk(doneFlag, ok);
    regRd(flash_tbl_pkg::IDX_CTL, rv);
    chk({rv[3], rv[1]}, {!ok, 1'b0});
    regWr(flash_tbl_pkg::IDX_STAT, 8'h00);
    chk(doneFlag, 1'b0);
  endtask : start

  initial begin
    rstn = 1'b0;
    porN = 1'b0;
    clkEn = 1'b1;
    regReq = '0;
    tblReq = '0;
    repeat (8) @(posedge clk);
    #10;
    rstn = 1'b1;
    porN = 1'b1;
    repeat (3) go();
    chk({stall, doneFlag}, 0);
    regRd(flash_tbl_pkg::IDX_UNLOCK, rv);
    chk(rv, 8'h00);
    regRd(3'h7, rv);
    chk(rv, 8'h00);
    foreach (rows[i]) begin
      setPtr(rows[i].p);
      tbl(1'b0, rows[i].m);
      regRd(flash_tbl_pkg::IDX_LATCH, rv);
      chk(rv, i_flash_array_model.peek(rows[i].a));
      regRd(flash_tbl_pkg::IDX_PTRL, p[7:0]);
      regRd(flash_tbl_pkg::IDX_PTRH, p[15:8]);
      regRd(flash_tbl_pkg::IDX_PTRU, rv);
      p[21:16] = rv[5:0];
      chk(p, rows[i].q);
    end
    // Three short writes into row 1, last one leaves the pointer mid-row
    setPtr(22'h000040);
    o0 = i_flash_array_model.peek(22'h000040);
    wrCnt = 0;
    regWr(flash_tbl_pkg::IDX_LATCH, 8'h0f);
    tbl(1'b1, flash_tbl_pkg::PM_POSTINC);
    regWr(flash_tbl_pkg::IDX_LATCH, 8'hf0);
    tbl(1'b1, flash_tbl_pkg::PM_POSTINC);
    regWr(flash_tbl_pkg::IDX_LATCH, 8'h00);
    tbl(1'b1, flash_tbl_pkg::PM_KEEP);
    repeat (3) go();
    chk(wrCnt, 0);
    start(8'h84, 8'haa, 1'b0, 1'b1);
    chk(i_flash_array_model.peek(22'h000040), o0 & 8'h0f);
    chk(i_flash_array_model.peek(22'h000041), 8'h41 & 8'hf0);
    chk(i_flash_array_model.peek(22'h000042), 8'h00);
    chk(i_flash_array_model.peek(22'h000043), 8'h43);
    chk(wrCnt, 3);
    start(8'h84, 8'haa, 1'b0, 1'b1);
    chk(wrCnt, 3);
    setPtr(22'h00007f);
    erCnt = 0;
    start(8'h94, 8'haa, 1'b0, 1'b1);
    chk({erCnt[7:0], erRow}, {8'h01, 16'h0001});
    chk(i_flash_array_model.peek(22'h000040), 8'hff);
    chk(i_flash_array_model.peek(22'h00007f), 8'hff);
    chk(i_flash_array_model.peek(22'h00003f), 8'h3f);
    chk(i_flash_array_model.peek(22'h000080), 8'h80);
    for (int i = 0; i < 4; i++) start(badC[i], badK[i], i == 2, 1'b0);
    // Frozen clock enable drops a latch write
    clkEn = 1'b0;
    regWr(flash_tbl_pkg::IDX_LATCH, 8'h5a);
    clkEn = 1'b1;
    regRd(flash_tbl_pkg::IDX_LATCH, rv);
    chk(rv, 8'h00);
    // Device reset in the middle of a long write
    setPtr(22'h000080);
    regWr(flash_tbl_pkg::IDX_LATCH, 8'h00);
    tbl(1'b1, flash_tbl_pkg::PM_KEEP);
    unlockStart(8'h84, 8'haa, 1'b0);
    repeat (20) go();
    rstn = 1'b0;
    go();
    rstn = 1'b1;
    repeat (3) go();
    chk(stall, 1'b0);
    regRd(flash_tbl_pkg::IDX_CTL, rv);
    chk(rv[3], 1'b1);
    wrCnt = 0;
    start(8'h84, 8'haa, 1'b0, 1'b1);
    chk(wrCnt, 0);
    give_verdict();
  end
endmodule : flash_self_program_table_access_test
